// ---- include/boot_query_defines.svh ----
// Purpose: shared constants of the boot command packet handler
// Assumes: byte-serial link, one packet handled at a time
// Notes: definitions only
`ifndef BOOT_QUERY_DEFINES_SVH
`define BOOT_QUERY_DEFINES_SVH

// ------------------------------------------------------------
// framing bytes
// ------------------------------------------------------------
`define START_OF_COMMAND_BYTE 8'h01
`define START_OF_RESPONSE_BYTE 8'h81
`define END_OF_PACKET_BYTE 8'h03
`define UNUSED_CODE_BYTE 8'hFF
`define STATUS_OK 8'h00
`define ERROR_RESPONSE_BIT 8'h80

// ------------------------------------------------------------
// command codes and lengths
// ------------------------------------------------------------
`define CMD_ROLLBACK_QUERY 8'h4D
`define CMD_INQUIRY 8'h00
`define CMD_LENGTH 16'h0001
`define DATA_REPLY_LENGTH 8'h05
`define STATUS_REPLY_LENGTH 8'h0A
`define DATA_REPLY_LAST 4'h9
`define STATUS_REPLY_LAST 4'hE

// ------------------------------------------------------------
// rollback configuration layout
// ------------------------------------------------------------
`define BL_LOCK_BIT 5
`define NS_LOCKS_MSB 4
`define NS_LOCKS_LSB 1
`define S_LOCK_BIT 0
`define NS_CNT_CFG_MSB 17
`define NS_CNT_CFG_LSB 16

`endif

// ---- include/boot_query_pkg.sv ----
// Purpose: types of the boot command packet handler
// Assumes: constants come from boot_query_defines.svh
// Notes: one-hot parser states
package boot_query_pkg;

  typedef enum logic [5:0] {
    ST_WAIT_START = 6'h01,
    ST_LEN_HIGH = 6'h02,
    ST_LEN_LOW = 6'h04,
    ST_BODY = 6'h08,
    ST_END = 6'h10,
    ST_SEND = 6'h20
  } parse_state_t;

  typedef enum logic [1:0] {
    AUTH_LEVEL_ZERO = 2'h0,
    AUTH_LEVEL_ONE = 2'h1,
    AUTH_LEVEL_TWO = 2'h2,
    AUTH_LEVEL_THREE = 2'h3
  } auth_level_t;

  typedef struct packed {
    logic bootloader_rollback_lock;
    logic [3:0] nonsecure_rollback_locks;
    logic secure_rollback_lock;
    logic [1:0] nonsecure_counter_config;
  } rollback_fields_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;

endpackage

// ---- hw/reply_skid_buffer.sv ----
// Purpose: two-entry buffer on the reply byte path
// Assumes: head entry always in slot 0
// Notes: output data straight from a register
`timescale 1ns/1ps
module reply_skid_buffer import boot_query_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;
  logic push;
  logic pop;

  assign in_ready = (s_reg.count != 2'h2);
  assign out_valid = (s_reg.count != 2'h0);
  assign out_data = s_reg.slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (pop) begin
      s_next.slot0 = s_reg.slot1;
    end
    if (push) begin
      if (s_reg.count == 2'h0 || (s_reg.count == 2'h1 && pop)) begin
        s_next.slot0 = in_data;
      end else begin
        s_next.slot1 = in_data;
      end
    end
    s_next.count = s_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ---- hw/rollback_config_store.sv ----
// Purpose: registered copy of the rollback configuration area
// Assumes: byte 0 of the area sits in bits 7:0
// Notes: read only, never written by the handler
`timescale 1ns/1ps
`include "boot_query_defines.svh"
module rollback_config_store import boot_query_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] area_word,
  output logic [31:0] area_q,
  output rollback_fields_t fields_q
);

  typedef struct packed {
    logic [31:0] word;
    rollback_fields_t fields;
  } store_state_t;

  store_state_t s_reg;
  store_state_t s_next;

  always_comb begin
    s_next.word = area_word;
    // (RULE15) field layout
    s_next.fields.bootloader_rollback_lock = area_word[`BL_LOCK_BIT];
    s_next.fields.nonsecure_rollback_locks = area_word[`NS_LOCKS_MSB:`NS_LOCKS_LSB];
    s_next.fields.secure_rollback_lock = area_word[`S_LOCK_BIT];
    s_next.fields.nonsecure_counter_config = area_word[`NS_CNT_CFG_MSB:`NS_CNT_CFG_LSB];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign area_q = s_reg.word;
  assign fields_q = s_reg.fields;

endmodule

// ---- hw/boot_arc_query_inquiry_handler.sv ----
// Purpose: command packet checker and responder for two boot commands
// Assumes: rx bytes synchronous to clk, one packet at a time
// Notes: unknown command codes are dropped without reply
`timescale 1ns/1ps
`include "boot_query_defines.svh"

// Function
// (RULE1) Drop bytes until a start byte, which opens a new packet.
// (RULE2) Missing end byte answers packet error.
// (RULE3) Wrong check byte answers checksum error.
// (RULE4) Length outside general packet format answers packet error; zero length is dropped without reply.
// (RULE5) Length not matching the command answers packet error.
// (RULE6) After any error, skip the command, keep memory, wait again.
// (RULE7) Report only the highest-priority error in the fixed order.
// (RULE8) Host sends rollback query: start, 00h 01h, 4Dh, check, end.
// (RULE9) Rollback query refused with acceptance error when lifecycle forbids.
// (RULE10) Rollback query at authentication level one or zero answers secure error.
// (RULE11) Rollback reply: 81h, 00h 05h, 4Dh, four area bytes low first.
// (RULE12) Failed rollback query replies length 0Ah, code CDh, status, detail, address.
// (RULE13) Detail and address fields carry the unused code on every error.
// (RULE14) Successful rollback query sends data, leaves memory, waits again.
// (RULE15) Area layout: locks in byte 0, counter config in byte 2 bits 1:0.
// (RULE16) Host sends inquiry: 00h 01h, code 00h, check FFh.
// (RULE17) Inquiry refused while encrypted write pending without reset.
// (RULE18) Inquiry OK reply: length 0Ah, code 00h, status 00h, check FEh.
// (RULE19) Failed inquiry replies with code 80h, status, detail and address.
// (RULE20) Passed inquiry sends OK, leaves memory, stays ready.
// (RULE21) Check byte makes modulo-256 sum of length through check zero.
module boot_arc_query_inquiry_handler import boot_query_pkg::*; #(
  parameter logic [15:0] MAX_PACKET_LENGTH = 16'h0400,
  parameter logic [7:0] STS_PACKET_ERROR = 8'hC1,
  parameter logic [7:0] STS_CHECKSUM_ERROR = 8'hC2,
  parameter logic [7:0] STS_ACCEPT_ERROR = 8'hC3,
  parameter logic [7:0] STS_SECURE_ERROR = 8'hC4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic lifecycle_allows_query,
  input wire auth_level_t auth_level,
  input wire logic encrypted_write_done,
  input wire logic [31:0] rollback_area_word,
  output rollback_fields_t rollback_fields,
  output logic handler_busy
);

  // ----------------------------------------------------------
  // reset release
  // ----------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    parse_state_t state;
    logic [15:0] length;
    logic [15:0] count;
    logic [7:0] rx_sum;
    logic [7:0] code;
    logic enc_pending;
    logic is_data_reply;
    logic [7:0] reply_code;
    logic [7:0] status;
    logic [31:0] area;
    logic [3:0] tx_index;
    logic [7:0] tx_sum;
  } handler_state_t;

  handler_state_t s_reg;
  handler_state_t s_next;
  logic [31:0] area_q;
  logic buf_in_ready;
  logic buf_push;
  byte_beat_t tx_beat;
  logic rx_take;
  logic [7:0] sum_with_byte;
  logic etx_ok;
  logic sum_ok;
  logic format_ok;
  logic cmd_len_ok;
  logic accept_ok;
  logic secure_ok;
  logic known_code;
  logic [3:0] last_index;
  logic [7:0] status_pick;

  rollback_config_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .area_word(rollback_area_word),
    .area_q(area_q),
    .fields_q(rollback_fields)
  );

  reply_skid_buffer #(
    .WIDTH(8)
  ) u_reply_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(tx_beat.data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  // ----------------------------------------------------------
  // packet checks
  // ----------------------------------------------------------
  assign rx_ready = (s_reg.state != ST_SEND);
  assign rx_take = rx_valid && rx_ready;
  assign handler_busy = (s_reg.state != ST_WAIT_START);
  assign sum_with_byte = s_reg.rx_sum + rx_data;
  assign etx_ok = (rx_data == `END_OF_PACKET_BYTE);
  // (RULE21) received sum must come to zero
  assign sum_ok = (s_reg.rx_sum == 8'h00);
  assign format_ok = (s_reg.length != 16'h0000) && (s_reg.length <= MAX_PACKET_LENGTH);
  assign cmd_len_ok = (s_reg.length == `CMD_LENGTH);
  assign known_code = (s_reg.length != 16'h0000)
    && ((s_reg.code == `CMD_ROLLBACK_QUERY) || (s_reg.code == `CMD_INQUIRY));
  // (RULE9) lifecycle gate; (RULE17) pending encrypted write gate
  assign accept_ok = (s_reg.code == `CMD_ROLLBACK_QUERY) ? lifecycle_allows_query
    : !s_reg.enc_pending;
  // (RULE10) low authentication refuses the rollback query
  assign secure_ok = (s_reg.code != `CMD_ROLLBACK_QUERY)
    || !((auth_level == AUTH_LEVEL_ONE) || (auth_level == AUTH_LEVEL_ZERO));

  // (RULE7) priority of error reports
  always_comb begin
    if (!etx_ok) begin
      // (RULE2) missing end byte
      status_pick = STS_PACKET_ERROR;
    end else if (!sum_ok) begin
      // (RULE3) check byte mismatch
      status_pick = STS_CHECKSUM_ERROR;
    end else if (!format_ok) begin
      // (RULE4) general format length
      status_pick = STS_PACKET_ERROR;
    end else if (!cmd_len_ok) begin
      // (RULE5) command length
      status_pick = STS_PACKET_ERROR;
    end else if (!accept_ok) begin
      status_pick = STS_ACCEPT_ERROR;
    end else if (!secure_ok) begin
      status_pick = STS_SECURE_ERROR;
    end else begin
      status_pick = `STATUS_OK;
    end
  end

  // ----------------------------------------------------------
  // reply byte generator
  // ----------------------------------------------------------
  assign last_index = s_reg.is_data_reply ? `DATA_REPLY_LAST : `STATUS_REPLY_LAST;

  always_comb begin
    tx_beat.valid = (s_reg.state == ST_SEND);
    // (RULE11) (RULE12) (RULE18) (RULE19) reply framing
    case (s_reg.tx_index)
      4'h0: tx_beat.data = `START_OF_RESPONSE_BYTE;
      4'h1: tx_beat.data = 8'h00;
      4'h2: tx_beat.data = s_reg.is_data_reply ? `DATA_REPLY_LENGTH : `STATUS_REPLY_LENGTH;
      4'h3: tx_beat.data = s_reg.reply_code;
      default: tx_beat.data = `END_OF_PACKET_BYTE;
    endcase
    if (s_reg.is_data_reply) begin
      // (RULE11) area bytes, lowest address first
      case (s_reg.tx_index)
        4'h4: tx_beat.data = s_reg.area[7:0];
        4'h5: tx_beat.data = s_reg.area[15:8];
        4'h6: tx_beat.data = s_reg.area[23:16];
        4'h7: tx_beat.data = s_reg.area[31:24];
        4'h8: tx_beat.data = 8'h00 - s_reg.tx_sum;
        default: tx_beat.data = tx_beat.data;
      endcase
    end else if (s_reg.tx_index == 4'h4) begin
      tx_beat.data = s_reg.status;
    end else if (s_reg.tx_index >= 4'h5 && s_reg.tx_index <= 4'hC) begin
      // (RULE13) unused code in detail and address
      tx_beat.data = `UNUSED_CODE_BYTE;
    end else if (s_reg.tx_index == 4'hD) begin
      // (RULE21) reply check byte
      tx_beat.data = 8'h00 - s_reg.tx_sum;
    end
  end

  assign buf_push = tx_beat.valid;

  // ----------------------------------------------------------
  // parser and sequencer
  // ----------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // (RULE17) sticky until device reset
    if (encrypted_write_done) begin
      s_next.enc_pending = 1'b1;
    end
    case (s_reg.state)
      ST_WAIT_START: begin
        // (RULE1) hunt for start byte
        if (rx_take && rx_data == `START_OF_COMMAND_BYTE) begin
          s_next.state = ST_LEN_HIGH;
          s_next.rx_sum = 8'h00;
          s_next.code = 8'h00;
        end
      end
      ST_LEN_HIGH: begin
        if (rx_take) begin
          s_next.length[15:8] = rx_data;
          s_next.rx_sum = sum_with_byte;
          s_next.state = ST_LEN_LOW;
        end
      end
      ST_LEN_LOW: begin
        if (rx_take) begin
          s_next.length[7:0] = rx_data;
          s_next.rx_sum = sum_with_byte;
          s_next.count = 16'h0000;
          s_next.state = ST_BODY;
        end
      end
      ST_BODY: begin
        if (rx_take) begin
          if (s_reg.count == 16'h0000 && s_reg.length != 16'h0000) begin
            s_next.code = rx_data;
          end
          s_next.rx_sum = sum_with_byte;
          s_next.count = s_reg.count + 16'h0001;
          if (s_reg.count == s_reg.length) begin
            s_next.state = ST_END;
          end
        end
      end
      ST_END: begin
        if (rx_take) begin
          // (RULE6) errors only reply, never touch memory
          s_next.state = known_code ? ST_SEND : ST_WAIT_START;
          s_next.status = status_pick;
          s_next.area = area_q;
          s_next.tx_index = 4'h0;
          s_next.tx_sum = 8'h00;
          s_next.is_data_reply = (s_reg.code == `CMD_ROLLBACK_QUERY)
            && (status_pick == `STATUS_OK);
          // (RULE12) (RULE19) error code sets top bit
          s_next.reply_code = (status_pick == `STATUS_OK) ? s_reg.code
            : (s_reg.code | `ERROR_RESPONSE_BIT);
        end
      end
      ST_SEND: begin
        if (buf_in_ready) begin
          if (s_reg.tx_index != 4'h0) begin
            s_next.tx_sum = s_reg.tx_sum + tx_beat.data;
          end
          s_next.tx_index = s_reg.tx_index + 4'h1;
          // (RULE14) (RULE20) back to waiting after reply
          if (s_reg.tx_index == last_index) begin
            s_next.state = ST_WAIT_START;
          end
        end
      end
      default: begin
        s_next.state = ST_WAIT_START;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{state: ST_WAIT_START, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_start_hunt_discard: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_WAIT_START && rx_valid && rx_data != `START_OF_COMMAND_BYTE)
    |=> (s_reg.state == ST_WAIT_START))
    else $error("non-start byte left the hunt state");

  a_missing_end_error: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_END && rx_valid && !etx_ok && known_code)
    |=> (s_reg.state == ST_SEND && s_reg.status == STS_PACKET_ERROR))
    else $error("missing end byte not reported as packet error");

  a_checksum_error_pick: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_END && rx_valid && etx_ok && known_code && !sum_ok)
    |=> (s_reg.status == STS_CHECKSUM_ERROR))
    else $error("bad check byte not reported");

  a_cmd_length_error: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_END && rx_valid && etx_ok && sum_ok && known_code && !cmd_len_ok)
    |=> (s_reg.status == STS_PACKET_ERROR))
    else $error("wrong command length not reported");

  a_secure_error_pick: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_END && rx_valid && etx_ok && sum_ok && cmd_len_ok
      && s_reg.code == `CMD_ROLLBACK_QUERY && lifecycle_allows_query
      && auth_level == AUTH_LEVEL_ZERO)
    |=> (s_reg.status == STS_SECURE_ERROR && s_reg.reply_code == 8'hCD))
    else $error("low authentication not refused");

  a_inquiry_accept_gate: assert property ( // RULE17
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_END && rx_valid && etx_ok && sum_ok && cmd_len_ok
      && s_reg.code == `CMD_INQUIRY && s_reg.enc_pending)
    |=> (s_reg.status == STS_ACCEPT_ERROR && s_reg.reply_code == 8'h80))
    else $error("inquiry accepted after encrypted write");

  a_reply_check_byte: assert property ( // RULE21
    @(posedge clk) disable iff (!rst_n)
    (buf_push && buf_in_ready && s_reg.tx_index == last_index)
    |-> (s_reg.tx_sum == 8'h00 && tx_beat.data == `END_OF_PACKET_BYTE))
    else $error("reply sum not zero at the end byte");

  a_reply_opens_frame: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    ($rose(s_reg.state == ST_SEND)) |-> (s_reg.tx_index == 4'h0
      && tx_beat.data == `START_OF_RESPONSE_BYTE))
    else $error("reply does not open with response start byte");

  a_send_blocks_rx: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_n)
    (s_reg.state == ST_SEND) |-> !rx_ready)
    else $error("receive open while replying");

endmodule

// ---- verif/host_link_model.sv ----
// Purpose: host tool model, feeds command bytes and collects reply bytes
// Assumes: bench fills send_q and reads recv_q
// Notes: stall_lvl out of 128 sets how often the reply side is held off
`timescale 1ns/1ps
module host_link_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic [6:0] stall_lvl
);
  logic [7:0] send_q[$];
  logic [7:0] recv_q[$];
  logic took;
  integer seed = 32'h43665AB7;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    took = 1'b0;
  end

  always @(posedge clk) begin
    took <= rx_valid && rx_ready;
    if (tx_valid && tx_ready)
      recv_q.push_back(tx_data);
  end

  always @(negedge clk) begin
    if (took && send_q.size() > 0)
      void'(send_q.pop_front());
    rx_valid = (send_q.size() > 0);
    // idle line toggles each cycle between the inverse of the last byte and the byte itself
    rx_data = rx_valid ? send_q[0] : ~rx_data;
    tx_ready = (($random(seed) & 32'h7F) >= {25'h0, stall_lvl});
  end
endmodule

// ---- verif/boot_arc_query_inquiry_handler_tb_top.sv ----
// Purpose: self-checking bench of the boot command packet handler
// Assumes: host model on the byte link, side inputs driven at falling edge
// Notes: status codes set here and handed to the design
`timescale 1ns/1ps
`include "boot_query_defines.svh"
module boot_arc_query_inquiry_handler_tb_top import boot_query_pkg::*;;
  localparam logic [7:0] STS_PKT = 8'hC1;
  localparam logic [7:0] STS_CHK = 8'hC2;
  localparam logic [7:0] STS_ACC = 8'hC3;
  localparam logic [7:0] STS_SEC = 8'hC4;

  logic clk;
  logic reset_n;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic lifecycle_ok;
  auth_level_t auth;
  logic ewrite;
  logic [31:0] area;
  rollback_fields_t fields;
  logic busy;
  logic [6:0] stall;
  logic [7:0] exp_q[$];
  int err_count;
  int check_count;
  integer seed;

  // ------------------------------------------------------------
  // design and host
  // ------------------------------------------------------------
  boot_arc_query_inquiry_handler #(
    .STS_PACKET_ERROR(STS_PKT),
    .STS_CHECKSUM_ERROR(STS_CHK),
    .STS_ACCEPT_ERROR(STS_ACC),
    .STS_SECURE_ERROR(STS_SEC)
  ) dut_u (
    .clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .lifecycle_allows_query(lifecycle_ok), .auth_level(auth),
    .encrypted_write_done(ewrite), .rollback_area_word(area),
    .rollback_fields(fields), .handler_busy(busy)
  );

  host_link_model host_u (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .stall_lvl(stall)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // expected reply: data kind carries the area, else a status reply
  function automatic void build_exp(input logic data_kind, input logic [7:0] res,
                                    input logic [7:0] sts, input logic [31:0] area_v);
    logic [7:0] s;
    exp_q.delete();
    exp_q.push_back(`START_OF_RESPONSE_BYTE);
    exp_q.push_back(8'h00);
    exp_q.push_back(data_kind ? 8'h05 : 8'h0A);
    exp_q.push_back(res);
    if (data_kind) begin
      for (int i = 0; i < 4; i++)
        exp_q.push_back(area_v[8*i +: 8]);
    end else begin
      exp_q.push_back(sts);
      repeat (8) exp_q.push_back(8'hFF);
    end
    s = 8'h00;
    for (int i = 1; i < exp_q.size(); i++)
      s = s + exp_q[i];
    exp_q.push_back(8'h00 - s);
    exp_q.push_back(`END_OF_PACKET_BYTE);
  endfunction

  task automatic send_cmd(input logic [15:0] len, input logic [7:0] code,
                          input logic [7:0] sum_err, input logic [7:0] end_b);
    logic [7:0] s;
    s = len[15:8] + len[7:0] + code;
    host_u.send_q.push_back(`START_OF_COMMAND_BYTE);
    host_u.send_q.push_back(len[15:8]);
    host_u.send_q.push_back(len[7:0]);
    host_u.send_q.push_back(code);
    for (int i = 1; i < len; i++)
      host_u.send_q.push_back(8'h00);
    host_u.send_q.push_back(8'h00 - s + sum_err);
    host_u.send_q.push_back(end_b);
  endtask

  task automatic run_cmd(input logic [15:0] len, input logic [7:0] code,
                         input logic [7:0] sum_err, input logic [7:0] end_b, input string what);
    int n;
    send_cmd(len, code, sum_err, end_b);
    n = 0;
    while (host_u.recv_q.size() < exp_q.size() && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    @(negedge clk);
    check_count++;
    if (host_u.recv_q.size() != exp_q.size()) begin
      err_count++;
      $display("[ERR] %0t %s reply length %0d", $time, what, host_u.recv_q.size());
      stop_test();
    end
    for (int i = 0; i < exp_q.size(); i++)
      check_byte(host_u.recv_q[i], exp_q[i], what);
    check_byte({6'h00, busy, tx_valid}, 8'h00, "idle after reply");
    host_u.recv_q.delete();
    $display("test %s done", what);
  endtask

  task automatic run_err(input logic [15:0] len, input logic [7:0] code, input logic [7:0] sum_err,
                         input logic [7:0] end_b, input logic [7:0] sts, input string what);
    build_exp(1'b0, code | 8'h80, sts, 32'h0);
    run_cmd(len, code, sum_err, end_b, what);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h43665AB7;
    err_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    lifecycle_ok = 1'b1;
    auth = AUTH_LEVEL_TWO;
    ewrite = 1'b0;
    area = 32'h0;
    stall = 7'h00;
    do_reset();
    // junk ahead of the start byte is dropped
    host_u.send_q.push_back(8'h55);
    host_u.send_q.push_back(8'h03);
    // unknown command code gets no reply, any stray byte fails the inquiry below
    send_cmd(16'h0001, 8'h3A, 8'h00, 8'h03);
    build_exp(1'b0, `CMD_INQUIRY, `STATUS_OK, 32'h0);
    run_cmd(16'h0001, `CMD_INQUIRY, 8'h00, 8'h03, "inquiry");
    for (int k = 0; k < 6; k++) begin
      area = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $random(seed);
      auth = auth_level_t'(2 + k % 2);
      stall = (k % 2 == 1) ? 7'h50 : 7'h00;
      build_exp(1'b1, `CMD_ROLLBACK_QUERY, 8'h00, area);
      run_cmd(16'h0001, 8'h4D, 8'h00, 8'h03, "rollback data");
      check_byte(fields, {area[5], area[4:1], area[0], area[17:16]}, "fields");
    end
    for (int k = 0; k < 8; k++) begin
      lifecycle_ok = k[2];
      auth = auth_level_t'(k[1:0]);
      area = $random(seed);
      if (!k[2])
        build_exp(1'b0, 8'hCD, STS_ACC, 32'h0);
      else if (k[1:0] < 2)
        build_exp(1'b0, 8'hCD, STS_SEC, 32'h0);
      else
        build_exp(1'b1, 8'h4D, 8'h00, area);
      run_cmd(16'h0001, 8'h4D, 8'h00, 8'h03, "accept");
    end
    lifecycle_ok = 1'b0;
    auth = AUTH_LEVEL_ZERO;
    run_err(16'h0001, 8'h4D, 8'h01, 8'h04, STS_PKT, "no end");
    run_err(16'h0002, 8'h4D, 8'h05, 8'h03, STS_CHK, "sum");
    run_err(16'h0002, 8'h4D, 8'h00, 8'h03, STS_PKT, "cmd length");
    run_err(16'h0401, 8'h00, 8'h00, 8'h03, STS_PKT, "format length");
    run_err(16'h0001, 8'h00, 8'h00, 8'h02, STS_PKT, "inquiry no end");
    lifecycle_ok = 1'b1;
    auth = AUTH_LEVEL_THREE;
    area = 32'h00030021;
    build_exp(1'b1, 8'h4D, 8'h00, area);
    run_cmd(16'h0001, 8'h4D, 8'h00, 8'h03, "after errors");
    ewrite = 1'b1;
    @(negedge clk);
    ewrite = 1'b0;
    run_err(16'h0001, 8'h00, 8'h00, 8'h03, STS_ACC, "inquiry pending");
    do_reset();
    build_exp(1'b0, `CMD_INQUIRY, `STATUS_OK, 32'h0);
    run_cmd(16'h0001, `CMD_INQUIRY, 8'h00, 8'h03, "inquiry after reset");
    stop_test();
  end
endmodule
